// ==== hw/fmc_params.svh ====
`ifndef FMC_PARAMS_SVH
`define FMC_PARAMS_SVH

// Command codes of the configuration registers
`define FMC_CMD_MASK      8'hD7
`define FMC_CMD_DEBOUNCE  8'hD8
`define FMC_CMD_SCALE     8'hD9
`define FMC_CMD_OFFSET    8'hDA

// Reset values
`define FMC_RST_MASK      16'h0000
`define FMC_RST_DEBOUNCE  4'h0
`define FMC_RST_SCALE     16'hBA00
`define FMC_RST_OFFSET    16'h0000

// Fault type bit positions in the capture mask
`define FMC_BIT_PHASE     15
`define FMC_BIT_GROUP     14
`define FMC_BIT_CPU       13
`define FMC_BIT_UT        12
`define FMC_BIT_OT        11
`define FMC_BIT_PEAK_OC   10
`define FMC_BIT_PEAK_UC   9
`define FMC_BIT_EN_BUS    8
`define FMC_BIT_INPUT_OVERVOLTAGE    7
`define FMC_BIT_OUTPUT_OVERVOLTAGE   6
`define FMC_BIT_OUTPUT_UNDERVOLTAGE   5
`define FMC_BIT_STAGE     4
`define FMC_BIT_SYNC      3
`define FMC_BIT_INPUT_UNDERVOLTAGE    2
`define FMC_BIT_AVG_OC    1
`define FMC_BIT_AVG_UC    0

// Linear-11 field layout
`define FMC_L11_EXP_MSB   15
`define FMC_L11_EXP_LSB   11
`define FMC_L11_MANT_MSB  10

// Fraction bits of temperature values, extra quotient precision
`define FMC_TEMP_FRAC     4
`define FMC_DIV_GUARD     8

`endif

// ==== hw/fmc_pkg.sv ====
package fmc_pkg;

  typedef enum logic [1:0] {
    FMC_IDLE,
    FMC_DIV,
    FMC_DONE
  } fmc_div_state_e;

  typedef struct packed {
    logic signed [4:0]  expo;
    logic signed [10:0] mant;
  } fmc_lin11_s;

endpackage

// ==== hw/fmc_viol_if.sv ====
interface fmc_viol_if;
  logic       sample;
  logic       violate;
  logic [3:0] limit;
  logic       fault;

  modport core (
    output sample,
    output violate,
    output limit,
    input  fault
  );

  modport deb (
    input  sample,
    input  violate,
    input  limit,
    output fault
  );
endinterface

// ==== hw/fmc_debounce.sv ====
module fmc_debounce (
  input wire logic  clk_sys,
  input wire logic  rst_b,
  fmc_viol_if.deb   v
);
  logic [3:0] run;
  logic       hit;
  logic       fault;

  // Threshold reached on this violating sample: N earlier ones counted
  assign hit     = v.sample && v.violate && (run >= v.limit);
  assign v.fault = fault;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run   <= 4'h0;
      fault <= 1'b0;
    end else begin
      fault <= hit;
      if (v.sample && !v.violate) begin
        run <= 4'h0;
      end else if (v.sample && run < v.limit) begin
        run <= run + 4'h1;
      end else if (hit) begin
        run <= v.limit;
      end
    end
  end

  chk_fault_after_run: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(fault) |-> $past(v.violate) && $past(v.sample))
    else $error("fault declared without a violating sample");

  chk_clear_on_good: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    v.sample && !v.violate |=> run == 4'h0 && !fault)
    else $error("run not cleared by an in-limit sample");
endmodule

// ==== hw/fmc_top.sv ====
`include "fmc_params.svh"
module fmc_top #(
  parameter int TW = 16
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           cmd_code,
  input  wire logic                 cmd_wr,
  input  wire logic                 cmd_rd,
  input  wire logic [15:0]          cmd_wdata,
  input  wire logic                 write_protect,
  output logic                      rsp_valid,
  output logic [15:0]               rsp_data,
  output logic                      rsp_error,
  input  wire logic [15:0]          fault_evt,
  input  wire logic                 vout_sample,
  input  wire logic                 ov_violate,
  input  wire logic                 uv_violate,
  output logic                      ov_fault,
  output logic                      uv_fault,
  output logic                      capture_start,
  output logic [15:0]               capture_cause,
  input  wire logic                 ext_temp_valid,
  input  wire logic signed [TW-1:0] ext_temp,
  output logic                      temp2_valid,
  output logic signed [15:0]        temp2_reading
);
  localparam int NUMW     = TW + 1 + `FMC_DIV_GUARD + 16;
  localparam int CW       = $clog2(NUMW + 1);
  localparam int DONE_DLY = NUMW + 1;

  // Register file
  logic [15:0] fault_capture_mask;
  logic [3:0]  vfd_limit;
  logic [15:0] ext_temp_scale;
  logic [15:0] ext_temp_offset;

  logic hit_mask;
  logic hit_deb;
  logic hit_scale;
  logic hit_off;
  logic hit_any;
  logic wr_ok;
  logic [15:0] rd_mux;

  assign hit_mask  = cmd_code == `FMC_CMD_MASK;
  assign hit_deb   = cmd_code == `FMC_CMD_DEBOUNCE;
  assign hit_scale = cmd_code == `FMC_CMD_SCALE;
  assign hit_off   = cmd_code == `FMC_CMD_OFFSET;
  assign hit_any   = hit_mask | hit_deb | hit_scale | hit_off;
  assign wr_ok     = cmd_wr && hit_any && !write_protect;
  assign rd_mux    = hit_mask  ? fault_capture_mask :
                     hit_deb   ? {12'h000, vfd_limit} :
                     hit_scale ? ext_temp_scale :
                     hit_off   ? ext_temp_offset : 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_capture_mask <= `FMC_RST_MASK;
      vfd_limit          <= `FMC_RST_DEBOUNCE;
      ext_temp_scale     <= `FMC_RST_SCALE;
      ext_temp_offset    <= `FMC_RST_OFFSET;
    end else if (wr_ok) begin
      if (hit_mask)  fault_capture_mask <= cmd_wdata;
      if (hit_deb)   vfd_limit          <= cmd_wdata[3:0];
      if (hit_scale) ext_temp_scale     <= cmd_wdata;
      if (hit_off)   ext_temp_offset    <= cmd_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= cmd_wr | cmd_rd;
      rsp_data  <= (cmd_rd && !cmd_wr) ? rd_mux : 16'h0000;
      rsp_error <= (cmd_wr | cmd_rd) && (!hit_any || (cmd_wr && write_protect));
    end
  end

  // Output voltage debounce, one counter per limit
  fmc_viol_if ov_if ();
  fmc_viol_if uv_if ();

  assign ov_if.sample  = vout_sample;
  assign ov_if.violate = ov_violate;
  assign ov_if.limit   = vfd_limit;
  assign uv_if.sample  = vout_sample;
  assign uv_if.violate = uv_violate;
  assign uv_if.limit   = vfd_limit;

  fmc_debounce u_ov (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .v       (ov_if.deb)
  );

  fmc_debounce u_uv (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .v       (uv_if.deb)
  );

  // Fault response follows detection regardless of the mask
  assign ov_fault = ov_if.fault;
  assign uv_fault = uv_if.fault;

  // Capture trigger: every fault type, one mask bit each
  logic [15:0] evt_all;
  logic [15:0] evt_live;

  always_comb begin
    evt_all = fault_evt;
    evt_all[`FMC_BIT_OUTPUT_OVERVOLTAGE] = fault_evt[`FMC_BIT_OUTPUT_OVERVOLTAGE] | ov_if.fault;
    evt_all[`FMC_BIT_OUTPUT_UNDERVOLTAGE] = fault_evt[`FMC_BIT_OUTPUT_UNDERVOLTAGE] | uv_if.fault;
  end

  assign evt_live = evt_all & ~fault_capture_mask;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      capture_start <= 1'b0;
      capture_cause <= 16'h0000;
    end else begin
      capture_start <= |evt_live;
      capture_cause <= evt_live;
    end
  end

  // Second temperature: ext_temp / scale + offset, in 1/16 degree
  fmc_pkg::fmc_lin11_s scl;
  fmc_pkg::fmc_lin11_s ofs;
  assign scl = fmc_pkg::fmc_lin11_s'(ext_temp_scale);
  assign ofs = fmc_pkg::fmc_lin11_s'(ext_temp_offset);

  function automatic logic signed [15:0] sat16(
    input logic signed [39:0] x
  );
    if (x > 40'sh0000007FFF) begin
      sat16 = 16'sh7FFF;
    end else if (x < -40'sh0000008000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = x[15:0];
    end
  endfunction

  logic               t_neg;
  logic [TW:0]        t_mag;
  logic [NUMW-1:0]    num_base;
  logic [NUMW-1:0]    num_start;
  logic               y_neg;
  logic [10:0]        y_mag;
  logic signed [5:0]  ofs_sh;
  logic signed [39:0] ofs_ext;
  logic signed [39:0] ofs_val;

  assign t_neg    = ext_temp[TW-1];
  assign t_mag    = t_neg ? -{ext_temp[TW-1], ext_temp}
                          : {ext_temp[TW-1], ext_temp};
  assign num_base = NUMW'({t_mag, `FMC_DIV_GUARD'(0)});
  // Negative exponent multiplies the quotient, positive divides it
  assign num_start = scl.expo[4] ? num_base << (-scl.expo)
                                 : num_base >> scl.expo;
  assign y_neg    = scl.mant[10];
  assign y_mag    = y_neg ? -scl.mant : scl.mant;
  assign ofs_sh   = 6'(scl.expo * 0) + 6'(ofs.expo) + 6'(`FMC_TEMP_FRAC);
  assign ofs_ext  = 40'(ofs.mant);
  assign ofs_val  = ofs_sh[5] ? ofs_ext >>> (-ofs_sh) : ofs_ext <<< ofs_sh;

  fmc_pkg::fmc_div_state_e st;
  fmc_pkg::fmc_div_state_e next_st;
  logic [11:0]        rem;
  logic [NUMW-1:0]    quo;
  logic [CW-1:0]      cnt;
  logic               q_neg;
  logic [10:0]        dvs;
  logic [11:0]        rem_sh;
  logic               ge;
  logic signed [39:0] q_scaled;
  logic signed [39:0] q_signed;
  logic signed [39:0] sum;

  assign rem_sh   = {rem[10:0], quo[NUMW-1]};
  assign ge       = rem_sh >= {1'b0, dvs};
  assign q_scaled = 40'(quo >> `FMC_DIV_GUARD);
  assign q_signed = q_neg ? -q_scaled : q_scaled;
  assign sum      = 40'(sat16(q_signed)) + ofs_val;

  always_comb begin
    next_st = st;
    unique case (st)
      fmc_pkg::FMC_IDLE: begin
        if (ext_temp_valid) next_st = fmc_pkg::FMC_DIV;
      end
      fmc_pkg::FMC_DIV: begin
        if (cnt == CW'(NUMW - 1)) next_st = fmc_pkg::FMC_DONE;
      end
      fmc_pkg::FMC_DONE: begin
        next_st = fmc_pkg::FMC_IDLE;
      end
      default: next_st = fmc_pkg::FMC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st    <= fmc_pkg::FMC_IDLE;
      rem   <= 12'h000;
      quo   <= '0;
      cnt   <= '0;
      q_neg <= 1'b0;
      dvs   <= 11'h000;
    end else begin
      st <= next_st;
      if (st == fmc_pkg::FMC_IDLE && ext_temp_valid) begin
        rem   <= 12'h000;
        quo   <= num_start;
        cnt   <= '0;
        q_neg <= t_neg ^ y_neg;
        dvs   <= y_mag;
      end else if (st == fmc_pkg::FMC_DIV) begin
        rem <= ge ? rem_sh - {1'b0, dvs} : rem_sh;
        quo <= {quo[NUMW-2:0], ge};
        cnt <= cnt + CW'(1);
      end
    end
  end

  // A zero scale has no defined quotient; full scale is reported
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      temp2_valid   <= 1'b0;
      temp2_reading <= 16'sh0000;
    end else begin
      temp2_valid <= st == fmc_pkg::FMC_DONE;
      if (st == fmc_pkg::FMC_DONE) begin
        temp2_reading <= (dvs == 11'h000)
                         ? (q_neg ? -16'sh8000 : 16'sh7FFF)
                         : sat16(sum);
      end
    end
  end

  // Checks
  // Mask that was live when the current capture_cause was formed
  logic [15:0] cap_mask_used;
  logic [15:0] cap_leak;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cap_mask_used <= `FMC_RST_MASK;
    end else begin
      cap_mask_used <= fault_capture_mask;
    end
  end

  assign cap_leak = capture_cause & cap_mask_used;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_mask_blocks_cap: assert property (
    |(evt_all & fault_capture_mask) && !(|evt_live) |=> !capture_start)
    else $error("masked fault started a capture");

  chk_unmask_starts: assert property (
    |(evt_all & ~fault_capture_mask) |=> capture_start
      && capture_cause == $past(evt_all & ~fault_capture_mask))
    else $error("unmasked fault did not start a capture");

  chk_phase_group: assert property (
    fault_capture_mask[`FMC_BIT_PHASE] |=> !capture_cause[`FMC_BIT_PHASE])
    else $error("phase fault captured while masked");

  chk_group_bit: assert property (
    fault_capture_mask[`FMC_BIT_GROUP] |=> !capture_cause[`FMC_BIT_GROUP])
    else $error("group fault captured while masked");

  chk_peak_masks: assert property (
    !cap_leak[`FMC_BIT_PEAK_OC] && !cap_leak[`FMC_BIT_PEAK_UC])
    else $error("masked peak current fault captured");

  chk_en_bus_mask: assert property (
    !cap_leak[`FMC_BIT_EN_BUS])
    else $error("masked enable pin fault captured");

  chk_vin_masks: assert property (
    !cap_leak[`FMC_BIT_INPUT_OVERVOLTAGE] && !cap_leak[`FMC_BIT_INPUT_UNDERVOLTAGE])
    else $error("masked input voltage fault captured");

  chk_stage_mask: assert property (
    !cap_leak[`FMC_BIT_STAGE])
    else $error("masked power stage fault captured");

  chk_sync_mask: assert property (
    !cap_leak[`FMC_BIT_SYNC])
    else $error("masked synchronization fault captured");

  chk_avg_masks: assert property (
    !cap_leak[`FMC_BIT_AVG_OC] && !cap_leak[`FMC_BIT_AVG_UC])
    else $error("masked average current fault captured");

  chk_output_overvoltage_mask: assert property (
    ov_if.fault && fault_capture_mask[`FMC_BIT_OUTPUT_OVERVOLTAGE]
      |=> !capture_cause[`FMC_BIT_OUTPUT_OVERVOLTAGE])
    else $error("output overvoltage captured while masked");

  chk_resp_unmasked: assert property (
    vout_sample && vfd_limit == 4'h0
      |=> ov_fault == $past(ov_violate) && uv_fault == $past(uv_violate))
    else $error("fault response altered by the mask");

  chk_debounce_run: assert property (
    vfd_limit == 4'h2 && $stable(vfd_limit)
      ##0 (vout_sample && ov_violate)
      ##1 (vout_sample && ov_violate)
      ##1 (vout_sample && ov_violate)
      |=> ov_fault)
    else $error("OV not declared after three violations");

  chk_read_mask: assert property (
    cmd_rd && !cmd_wr && hit_mask |=> rsp_valid
      && rsp_data == $past(fault_capture_mask))
    else $error("mask read returned wrong data");

  chk_protect_write: assert property (
    cmd_wr && write_protect |=> rsp_error && $stable(fault_capture_mask))
    else $error("protected write changed a register");

  chk_temp_latency: assert property (
    st == fmc_pkg::FMC_IDLE && ext_temp_valid
      |-> ##DONE_DLY st == fmc_pkg::FMC_DONE ##1 temp2_valid)
    else $error("temperature result not on time");

  cov_masked_fault: cover property (
    |(fault_evt & fault_capture_mask) ##1 !capture_start);
  cov_capture: cover property (capture_start);
  cov_ov_declared: cover property (ov_fault && vfd_limit != 4'h0);
  cov_temp_done: cover property (temp2_valid && temp2_reading != 16'sh0000);
endmodule

// ==== sim/fmc_host.sv ====
module fmc_host (
  input  wire logic   clk_sys,
  output logic [7:0]  cmd_code,
  output logic        cmd_wr,
  output logic        cmd_rd,
  output logic [15:0] cmd_wdata,
  output logic        write_protect
);
  timeunit 1ns;
  timeprecision 1ps;

  // Expected {error, data} of each answer, oldest first
  logic [16:0] exp_q[$];

  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
    write_protect = 1'b0;
  end

  // One command per call; released code and data lines show the inverse value
  task automatic access(input logic wr, input logic [7:0] code,
                        input logic [15:0] wdata, input logic [16:0] exp);
    @(posedge clk_sys);
    cmd_code <= code;
    cmd_wdata <= wdata;
    cmd_wr <= wr;
    cmd_rd <= ~wr;
    exp_q.push_back(exp);
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~wdata;
  endtask

  task automatic protect(input logic p);
    @(posedge clk_sys);
    write_protect <= p;
  endtask
endmodule

// ==== sim/tb_fault_mask_ovuv_temp_cal.sv ====
`include "fmc_params.svh"
module tb_fault_mask_ovuv_temp_cal;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk_sys = 1'b0;
  logic               rst_b;
  logic [15:0]        fault_evt;
  logic               vout_sample;
  logic               ov_violate;
  logic               uv_violate;
  logic               ext_temp_valid;
  logic signed [15:0] ext_temp;
  logic [7:0]         cmd_code;
  logic               cmd_wr;
  logic               cmd_rd;
  logic [15:0]        cmd_wdata;
  logic               write_protect;
  logic               rsp_valid;
  logic [15:0]        rsp_data;
  logic               rsp_error;
  logic               ov_fault;
  logic               uv_fault;
  logic               capture_start;
  logic [15:0]        capture_cause;
  logic               temp2_valid;
  logic signed [15:0] temp2_reading;
  logic [16:0]        e;
  logic [15:0]        mask_m;
  logic [15:0]        cap_q[$];
  logic [1:0]         flt_q[$];
  logic [15:0]        temp_q[$];
  int                 fail_count;
  int                 check_count;
  int                 ovr;
  int                 uvr;
  int                 dn;
  int                 r;

  always #5 clk_sys = ~clk_sys;

  fmc_host fmc_host_i (.clk_sys(clk_sys), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .write_protect(write_protect));

  fmc_top fmc_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata), .write_protect(write_protect),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
    .fault_evt(fault_evt), .vout_sample(vout_sample),
    .ov_violate(ov_violate), .uv_violate(uv_violate),
    .ov_fault(ov_fault), .uv_fault(uv_fault),
    .capture_start(capture_start), .capture_cause(capture_cause),
    .ext_temp_valid(ext_temp_valid), .ext_temp(ext_temp),
    .temp2_valid(temp2_valid), .temp2_reading(temp2_reading));

  task automatic check(input string what, input logic [16:0] exp,
                       input logic [16:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Each result pops the oldest note; an extra result meets an unknown
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      e = (fmc_host_i.exp_q.size() != 0) ? fmc_host_i.exp_q.pop_front() : 'x;
      check("response", e, {rsp_error, rsp_data});
    end
    if (capture_start === 1'b1) begin
      e = (cap_q.size() != 0) ? {1'b0, cap_q.pop_front()} : 'x;
      check("capture_cause", e, {1'b0, capture_cause});
    end
    if (ov_fault === 1'b1 || uv_fault === 1'b1) begin
      e = (flt_q.size() != 0) ? {15'h0, flt_q.pop_front()} : 'x;
      check("ov_uv_fault", e, {15'h0, ov_fault, uv_fault});
    end
    if (temp2_valid === 1'b1) begin
      e = (temp_q.size() != 0) ? {1'b0, temp_q.pop_front()} : 'x;
      check("temp2_reading", e, {1'b0, temp2_reading});
    end
  end

  task automatic rd(input logic [7:0] code, input logic [16:0] exp);
    fmc_host_i.access(1'b0, code, 16'($urandom), exp);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    fmc_host_i.access(1'b1, code, d, 17'h00000);
  endtask

  task automatic wmask(input logic [15:0] m);
    wr(`FMC_CMD_MASK, m);
    mask_m = m;
  endtask

  task automatic evt(input logic [15:0] f);
    @(posedge clk_sys);
    fault_evt <= f;
    if ((f & ~mask_m) != 16'h0000) cap_q.push_back(f & ~mask_m);
    @(posedge clk_sys);
    fault_evt <= 16'h0000;
  endtask

  task automatic samp(input logic ov, input logic uv);
    logic       of;
    logic       uf;
    logic [15:0] c;
    @(posedge clk_sys);
    vout_sample <= 1'b1;
    ov_violate <= ov;
    uv_violate <= uv;
    ovr = ov ? ovr + 1 : 0;
    uvr = uv ? uvr + 1 : 0;
    of = ovr > dn;
    uf = uvr > dn;
    if (of | uf) flt_q.push_back({of, uf});
    c = {9'h000, of, uf, 5'h00} & ~mask_m;
    if (c != 16'h0000) cap_q.push_back(c);
  endtask

  // Gap cycle: violate lines toggle but no sample is judged
  task automatic gap();
    @(posedge clk_sys);
    vout_sample <= 1'b0;
    ov_violate <= ~ov_violate;
    uv_violate <= ~uv_violate;
  endtask

  // Second pulse lands while busy and must yield no extra result
  task automatic tmp(input logic [15:0] x, input logic [15:0] exp);
    @(posedge clk_sys);
    ext_temp <= x;
    ext_temp_valid <= 1'b1;
    temp_q.push_back(exp);
    @(posedge clk_sys);
    ext_temp_valid <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ext_temp_valid <= 1'b1;
    @(posedge clk_sys);
    ext_temp_valid <= 1'b0;
    for (int k = 0; k < 60 && temp_q.size() != 0; k++) @(posedge clk_sys);
  endtask

  initial begin
    rst_b = 1'b0;
    fault_evt = 16'h0000;
    vout_sample = 1'b0;
    ov_violate = 1'b0;
    uv_violate = 1'b0;
    ext_temp_valid = 1'b0;
    ext_temp = 16'h0000;
    mask_m = 16'h0000;
    dn = 0;
    ovr = 0;
    uvr = 0;
    void'($urandom(32'h89F6));
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(`FMC_CMD_MASK, 17'h00000);
    rd(`FMC_CMD_DEBOUNCE, 17'h00000);
    rd(`FMC_CMD_SCALE, 17'h0BA00);
    rd(`FMC_CMD_OFFSET, 17'h00000);
    rd(8'hDB, 17'h10000);
    wr(`FMC_CMD_DEBOUNCE, 16'hFFF2);
    rd(`FMC_CMD_DEBOUNCE, 17'h00002);
    dn = 2;
    fmc_host_i.protect(1'b1);
    fmc_host_i.access(1'b1, `FMC_CMD_MASK, 16'hFFFF, 17'h10000);
    fmc_host_i.protect(1'b0);
    rd(`FMC_CMD_MASK, 17'h00000);
    for (int i = 0; i < 16; i++) begin
      wmask(16'h0001 << i);
      evt(16'hFFFF);
    end
    wmask(16'hFFFF);
    evt(16'hFFFF);
    repeat (20) begin
      wmask(16'($urandom));
      evt(16'($urandom));
    end
    wmask(16'h0040);
    for (int i = 0; i < 16; i++) begin
      samp(1'(16'hF6EB >> i), 1'(16'h73F8 >> i));
      if (i == 7) gap();
    end
    samp(1'b0, 1'b0);
    gap();
    wr(`FMC_CMD_DEBOUNCE, 16'hFFF0);
    dn = 0;
    wmask(16'h0020);
    repeat (16) samp(1'($urandom), 1'($urandom));
    gap();
    tmp(16'd400, 16'd400);
    r = $urandom_range(4000) - 2000;
    tmp(16'(r), 16'(r));
    wr(`FMC_CMD_SCALE, 16'hC200);
    wr(`FMC_CMD_OFFSET, 16'h0005);
    tmp(16'hFE6E, 16'hFF87);
    tmp(16'd400, 16'd280);
    wr(`FMC_CMD_SCALE, 16'h0000);
    tmp(16'd400, 16'h7FFF);
    repeat (10) @(posedge clk_sys);
    r = cap_q.size() + flt_q.size() + temp_q.size()
        + fmc_host_i.exp_q.size();
    check("queues", 17'h00000, 17'(r));
    results();
  end

  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule
